// [logic/psdm_divider.sv]
// Purpose: Sequential unsigned 32 by 32 bit divider.
// Assumes: Divisor is non-zero when start_in is pulsed.
// Notes: One quotient bit per clock, result 33 cycles after start.
`timescale 1ns/1ps
module psdm_divider (
  input wire logic clock_in, // System clock.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic start_in, // One-cycle start pulse.
  input wire logic [31:0] dividend_in, // Numerator.
  input wire logic [31:0] divisor_in, // Denominator.
  output logic [31:0] quotient_out, // Quotient, valid with done_out.
  output logic done_out // One-cycle result pulse.
);

  psdm_pkg::psdm_div_type state_ff, nxt_state;
  logic [32:0] rem_ff, nxt_rem;
  logic [31:0] quo_ff, nxt_quo;
  logic [31:0] div_ff, nxt_div;
  logic [5:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;
  logic [32:0] trial;

  always_comb begin
    nxt_state = state_ff;
    nxt_rem = rem_ff;
    nxt_quo = quo_ff;
    nxt_div = div_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    trial = {rem_ff[31:0], quo_ff[31]};
    case (state_ff)
      psdm_pkg::PSDM_DIV_IDLE: begin
        if (start_in) begin
          nxt_state = psdm_pkg::PSDM_DIV_RUN;
          nxt_rem = 33'h000000000;
          nxt_quo = dividend_in;
          nxt_div = divisor_in;
          nxt_cnt = 6'h00;
        end
      end
      psdm_pkg::PSDM_DIV_RUN: begin
        if (trial >= {1'b0, div_ff}) begin
          nxt_rem = trial - {1'b0, div_ff};
          nxt_quo = {quo_ff[30:0], 1'b1};
        end else begin
          nxt_rem = trial;
          nxt_quo = {quo_ff[30:0], 1'b0};
        end
        nxt_cnt = cnt_ff + 6'h01;
        if (cnt_ff == 6'h1F) begin
          nxt_state = psdm_pkg::PSDM_DIV_IDLE;
          nxt_done = 1'b1;
        end
      end
      default: begin
        nxt_state = psdm_pkg::PSDM_DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_ff <= psdm_pkg::PSDM_DIV_IDLE;
      rem_ff <= 33'h000000000;
      quo_ff <= 32'h00000000;
      div_ff <= 32'h00000000;
      cnt_ff <= 6'h00;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign quotient_out = quo_ff;
  assign done_out = done_ff;

endmodule

// [logic/psdm_monitor.sv]
// Purpose: Pulse probe speed measurement and speed deviation / load failure monitoring.
// Assumes: All inputs synchronous to clock_in; motor speed given as unsigned rpm magnitude.
// Notes: Programmable times are in ms; speeds are in rpm.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "psdm_params.svh"

// How it works
// - Probe pulses come only from digital input three, nothing else.
// - Pulse trains up to 32 kHz are handled; sensor never exceeds that.
// - Probe speed is compared with motor speed; excess deviation triggers the response.
// - Configuration value 2 selects speed and load failure monitoring; resets to 1.
// - Programmable delay time governs evaluation; resets to 10 s.
// - Programmable response selector chooses the trip action; resets to 0.
// - Programmable permitted speed deviation sets tolerance; resets to 150 rpm.
// - Input select 23 routes digital input three; reset 0 means unconnected.
// - Edge select 0 counts rising edges, 1 falling; resets to 0.
// - Pulses per revolution scales the interval into speed; resets to 1.
// - No pulse within maximum measuring time forces measured speed to zero.
// - Every detected pulse restarts the measuring time supervision.
// - Measured speed is multiplied by the gear factor, default 1.
// - Invert bit three inverts digital input three; default all zeros.
// - Speed source 586 feeds probe speed to the evaluation; resets to 0.
// - Configuration 0 disabled, 1 torque plus load, 3 load failure only; torque is not monitored here, so 1 gives load failure only.
// - Motor on and input low longer than delay time raises load failure fault.
// - Response zero disables monitoring reactions; above zero enables them.
module psdm_monitor #(
  parameter int TICK_CYCLES = `PSDM_TICK_CYCLES
) (
  input wire logic clock_in, // System clock, 20 MHz.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic [3:0] digital_in_in, // Digital inputs, index 3 is the probe.
  input wire logic [15:0] motor_speed_in, // Motor-control actual speed, rpm.
  input wire logic motor_on_in, // Motor switched on.
  input wire logic [7:0] addr_in, // Register index.
  input wire logic [31:0] wdata_in, // Write data.
  input wire logic wr_in, // Write strobe.
  input wire logic rd_in, // Read strobe.
  output logic [31:0] rdata_out, // Read data, cycle after rd_in.
  output logic [15:0] probe_measured_speed_out, // Displayed probe speed, rpm.
  output logic deviation_trip_out, // Latched speed deviation trip.
  output logic load_failure_fault_out, // Latched load failure fault.
  output logic [7:0] response_out // Active response code, zero when idle.
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [15:0] bump16(input logic [15:0] v);
    bump16 = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // Configuration group.
  logic [1:0] load_monitor_config_ff, nxt_load_monitor_config;
  logic [15:0] load_monitor_delay_time_ff, nxt_load_monitor_delay_time;
  logic [7:0] load_monitor_response_ff, nxt_load_monitor_response;
  logic [15:0] permitted_speed_deviation_ff, nxt_permitted_speed_deviation;
  logic [15:0] probe_input_select_ff, nxt_probe_input_select;
  logic probe_edge_select_ff, nxt_probe_edge_select;
  logic [15:0] probe_pulses_per_rev_ff, nxt_probe_pulses_per_rev;
  logic [15:0] probe_max_measure_time_ff, nxt_probe_max_measure_time;
  logic [15:0] probe_gear_factor_ff, nxt_probe_gear_factor;
  logic [3:0] probe_input_invert_ff, nxt_probe_input_invert;
  logic [15:0] monitor_speed_source_ff, nxt_monitor_speed_source;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [3:0] status_bits;

  always_comb begin
    nxt_load_monitor_config = load_monitor_config_ff;
    nxt_load_monitor_delay_time = load_monitor_delay_time_ff;
    nxt_load_monitor_response = load_monitor_response_ff;
    nxt_permitted_speed_deviation = permitted_speed_deviation_ff;
    nxt_probe_input_select = probe_input_select_ff;
    nxt_probe_edge_select = probe_edge_select_ff;
    nxt_probe_pulses_per_rev = probe_pulses_per_rev_ff;
    nxt_probe_max_measure_time = probe_max_measure_time_ff;
    nxt_probe_gear_factor = probe_gear_factor_ff;
    nxt_probe_input_invert = probe_input_invert_ff;
    nxt_monitor_speed_source = monitor_speed_source_ff;
    if (wr_in) begin
      if (hit(addr_in, `PSDM_OFF_CONFIG)) nxt_load_monitor_config = wdata_in[1:0];
      if (hit(addr_in, `PSDM_OFF_DELAY)) nxt_load_monitor_delay_time = wdata_in[15:0];
      if (hit(addr_in, `PSDM_OFF_RESPONSE)) nxt_load_monitor_response = wdata_in[7:0];
      if (hit(addr_in, `PSDM_OFF_DEVIATION)) nxt_permitted_speed_deviation = wdata_in[15:0];
      if (hit(addr_in, `PSDM_OFF_INPUT_SEL)) nxt_probe_input_select = wdata_in[15:0];
      if (hit(addr_in, `PSDM_OFF_EDGE_SEL)) nxt_probe_edge_select = wdata_in[0];
      if (hit(addr_in, `PSDM_OFF_PULSES_REV)) nxt_probe_pulses_per_rev = wdata_in[15:0];
      if (hit(addr_in, `PSDM_OFF_MAX_TIME)) nxt_probe_max_measure_time = wdata_in[15:0];
      if (hit(addr_in, `PSDM_OFF_GEAR)) nxt_probe_gear_factor = wdata_in[15:0];
      if (hit(addr_in, `PSDM_OFF_INVERT)) nxt_probe_input_invert = wdata_in[3:0];
      if (hit(addr_in, `PSDM_OFF_SPEED_SRC)) nxt_monitor_speed_source = wdata_in[15:0];
    end
    nxt_rdata = 32'h00000000;
    if (rd_in) begin
      case (addr_in)
        `PSDM_OFF_CONFIG: nxt_rdata = {30'h00000000, load_monitor_config_ff};
        `PSDM_OFF_DELAY: nxt_rdata = {16'h0000, load_monitor_delay_time_ff};
        `PSDM_OFF_RESPONSE: nxt_rdata = {24'h000000, load_monitor_response_ff};
        `PSDM_OFF_DEVIATION: nxt_rdata = {16'h0000, permitted_speed_deviation_ff};
        `PSDM_OFF_INPUT_SEL: nxt_rdata = {16'h0000, probe_input_select_ff};
        `PSDM_OFF_EDGE_SEL: nxt_rdata = {31'h00000000, probe_edge_select_ff};
        `PSDM_OFF_PULSES_REV: nxt_rdata = {16'h0000, probe_pulses_per_rev_ff};
        `PSDM_OFF_MAX_TIME: nxt_rdata = {16'h0000, probe_max_measure_time_ff};
        `PSDM_OFF_GEAR: nxt_rdata = {16'h0000, probe_gear_factor_ff};
        `PSDM_OFF_INVERT: nxt_rdata = {28'h0000000, probe_input_invert_ff};
        `PSDM_OFF_SPEED_SRC: nxt_rdata = {16'h0000, monitor_speed_source_ff};
        `PSDM_OFF_MEAS_SPEED: nxt_rdata = {16'h0000, probe_measured_speed_out};
        `PSDM_OFF_STATUS: nxt_rdata = {28'h0000000, status_bits};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      load_monitor_config_ff <= `PSDM_RST_CONFIG;
      load_monitor_delay_time_ff <= 16'(`PSDM_DELAY_DEFAULT_S * `PSDM_MS_PER_S);
      load_monitor_response_ff <= `PSDM_RST_RESPONSE;
      permitted_speed_deviation_ff <= `PSDM_RST_DEVIATION;
      probe_input_select_ff <= `PSDM_RST_INPUT_SEL;
      probe_edge_select_ff <= `PSDM_RST_EDGE_SEL;
      probe_pulses_per_rev_ff <= `PSDM_RST_PULSES_REV;
      probe_max_measure_time_ff <= 16'(`PSDM_MAX_TIME_DEFAULT_S * `PSDM_MS_PER_S);
      probe_gear_factor_ff <= `PSDM_RST_GEAR;
      probe_input_invert_ff <= `PSDM_RST_INVERT;
      monitor_speed_source_ff <= `PSDM_RST_SPEED_SRC;
      rdata_ff <= 32'h00000000;
    end else begin
      load_monitor_config_ff <= nxt_load_monitor_config;
      load_monitor_delay_time_ff <= nxt_load_monitor_delay_time;
      load_monitor_response_ff <= nxt_load_monitor_response;
      permitted_speed_deviation_ff <= nxt_permitted_speed_deviation;
      probe_input_select_ff <= nxt_probe_input_select;
      probe_edge_select_ff <= nxt_probe_edge_select;
      probe_pulses_per_rev_ff <= nxt_probe_pulses_per_rev;
      probe_max_measure_time_ff <= nxt_probe_max_measure_time;
      probe_gear_factor_ff <= nxt_probe_gear_factor;
      probe_input_invert_ff <= nxt_probe_input_invert;
      monitor_speed_source_ff <= nxt_monitor_speed_source;
      rdata_ff <= nxt_rdata;
    end
  end

  // Measurement and monitoring group.
  logic probe_prev_ff, nxt_probe_prev;
  logic [15:0] tick_ff, nxt_tick;
  logic [31:0] period_ff, nxt_period;
  logic have_edge_ff, nxt_have_edge;
  logic [15:0] meas_ms_ff, nxt_meas_ms;
  psdm_pkg::psdm_calc_type calc_ff, nxt_calc;
  logic [15:0] speed_ff, nxt_speed;
  logic [15:0] dev_ms_ff, nxt_dev_ms;
  logic [15:0] low_ms_ff, nxt_low_ms;
  logic trip_ff, nxt_trip;
  logic fault_ff, nxt_fault;
  logic [7:0] resp_ff, nxt_resp;
  logic [31:0] div_den;
  logic div_start;
  logic [31:0] div_quo;
  logic div_done;
  logic probe_level, probe_edge, ms_pulse, timed_out, over_tol, dev_enable, lf_enable;
  logic [47:0] denom_wide, scaled;
  logic [15:0] actual_speed, speed_diff;
  logic clr_trip, clr_fault;

  psdm_divider u_divider (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .start_in(div_start),
    .dividend_in(32'(`PSDM_RPM_NUM)),
    .divisor_in(div_den),
    .quotient_out(div_quo),
    .done_out(div_done)
  );

  always_comb begin
    // Unrouted terminal reads as a constant low level, so no edges and no speed.
    probe_level = (probe_input_select_ff == `PSDM_PROBE_TERMINAL) &&
                  (digital_in_in[`PSDM_PROBE_DI] ^ probe_input_invert_ff[`PSDM_PROBE_DI]);
    probe_edge = probe_edge_select_ff ? (probe_prev_ff & ~probe_level) : (~probe_prev_ff & probe_level);
    ms_pulse = (tick_ff == 16'(TICK_CYCLES - 1));
    timed_out = (meas_ms_ff >= probe_max_measure_time_ff);
    actual_speed = (monitor_speed_source_ff == `PSDM_SPEED_SRC_PROBE) ? speed_ff : 16'h0000;
    speed_diff = (actual_speed > motor_speed_in) ? actual_speed - motor_speed_in : motor_speed_in - actual_speed;
    over_tol = (speed_diff > permitted_speed_deviation_ff);
    dev_enable = (load_monitor_config_ff == `PSDM_CFG_SPEED_LOAD) && (load_monitor_response_ff != 8'h00);
    lf_enable = (load_monitor_config_ff != `PSDM_CFG_DISABLED) && (load_monitor_response_ff != 8'h00) &&
                motor_on_in;
    status_bits = {timed_out, over_tol, fault_ff, trip_ff};
    clr_trip = wr_in && hit(addr_in, `PSDM_OFF_STATUS) && wdata_in[`PSDM_STAT_TRIP];
    clr_fault = wr_in && hit(addr_in, `PSDM_OFF_STATUS) && wdata_in[`PSDM_STAT_FAULT];
    denom_wide = {16'h0000, period_ff} * {32'h00000000, probe_pulses_per_rev_ff};
    div_den = (denom_wide[47:32] != 16'h0000) ? 32'hFFFFFFFF : denom_wide[31:0];
    scaled = {16'h0000, div_quo} * {32'h00000000, probe_gear_factor_ff};

    nxt_probe_prev = probe_level;
    nxt_tick = ms_pulse ? 16'h0000 : tick_ff + 16'h0001;
    nxt_period = (period_ff == 32'hFFFFFFFF) ? period_ff : period_ff + 32'h00000001;
    nxt_have_edge = have_edge_ff;
    nxt_meas_ms = (ms_pulse && !timed_out) ? meas_ms_ff + 16'h0001 : meas_ms_ff;
    nxt_calc = calc_ff;
    nxt_speed = speed_ff;
    div_start = 1'b0;
    if (probe_edge) begin
      nxt_period = 32'h00000001;
      nxt_meas_ms = 16'h0000;
      nxt_have_edge = 1'b1;
      // Divider latency is tens of cycles, far below the 625-cycle interval at the top pulse rate.
      if (have_edge_ff && !timed_out && calc_ff == psdm_pkg::PSDM_CALC_IDLE && div_den != 32'h00000000) begin
        div_start = 1'b1;
        nxt_calc = psdm_pkg::PSDM_CALC_DIV;
      end
    end
    case (calc_ff)
      psdm_pkg::PSDM_CALC_IDLE: begin
      end
      psdm_pkg::PSDM_CALC_DIV: begin
        if (div_done) nxt_calc = psdm_pkg::PSDM_CALC_SCALE;
      end
      psdm_pkg::PSDM_CALC_SCALE: begin
        nxt_calc = psdm_pkg::PSDM_CALC_IDLE;
        nxt_speed = (scaled[47:16] != 32'h00000000) ? 16'hFFFF : scaled[15:0];
      end
      default: nxt_calc = psdm_pkg::PSDM_CALC_IDLE;
    endcase
    if (timed_out) begin
      // A stale interval must not produce a speed, so measurement restarts from the next pulse.
      nxt_speed = 16'h0000;
      nxt_have_edge = probe_edge;
    end

    nxt_dev_ms = (dev_enable && over_tol) ? (ms_pulse ? bump16(dev_ms_ff) : dev_ms_ff) : 16'h0000;
    nxt_low_ms = (lf_enable && !probe_level) ? (ms_pulse ? bump16(low_ms_ff) : low_ms_ff) : 16'h0000;
    // Set wins over a clear written in the same cycle.
    nxt_trip = (trip_ff && !clr_trip) ||
               (dev_enable && over_tol && dev_ms_ff >= load_monitor_delay_time_ff);
    nxt_fault = (fault_ff && !clr_fault) ||
                (lf_enable && !probe_level && low_ms_ff >= load_monitor_delay_time_ff);
    nxt_resp = (nxt_trip || nxt_fault) ? load_monitor_response_ff : 8'h00;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      probe_prev_ff <= 1'b0;
      tick_ff <= 16'h0000;
      period_ff <= 32'h00000000;
      have_edge_ff <= 1'b0;
      meas_ms_ff <= 16'h0000;
      calc_ff <= psdm_pkg::PSDM_CALC_IDLE;
      speed_ff <= 16'h0000;
      dev_ms_ff <= 16'h0000;
      low_ms_ff <= 16'h0000;
      trip_ff <= 1'b0;
      fault_ff <= 1'b0;
      resp_ff <= 8'h00;
    end else begin
      probe_prev_ff <= nxt_probe_prev;
      tick_ff <= nxt_tick;
      period_ff <= nxt_period;
      have_edge_ff <= nxt_have_edge;
      meas_ms_ff <= nxt_meas_ms;
      calc_ff <= nxt_calc;
      speed_ff <= nxt_speed;
      dev_ms_ff <= nxt_dev_ms;
      low_ms_ff <= nxt_low_ms;
      trip_ff <= nxt_trip;
      fault_ff <= nxt_fault;
      resp_ff <= nxt_resp;
    end
  end

  assign rdata_out = rdata_ff;
  assign probe_measured_speed_out = speed_ff;
  assign deviation_trip_out = trip_ff;
  assign load_failure_fault_out = fault_ff;
  assign response_out = resp_ff;

endmodule

// [shared/psdm_params.svh]
// Purpose: Constants of the pulse probe speed deviation monitor.
// Assumes: 20 MHz system clock, ms time base for all programmable delays.
// Notes: Offsets are word indexes on the plain register port.
`ifndef PSDM_PARAMS_SVH
`define PSDM_PARAMS_SVH

`define PSDM_ADDR_W 8
`define PSDM_DATA_W 32

`define PSDM_OFF_CONFIG 8'h00
`define PSDM_OFF_DELAY 8'h01
`define PSDM_OFF_RESPONSE 8'h02
`define PSDM_OFF_DEVIATION 8'h03
`define PSDM_OFF_INPUT_SEL 8'h04
`define PSDM_OFF_EDGE_SEL 8'h05
`define PSDM_OFF_PULSES_REV 8'h06
`define PSDM_OFF_MAX_TIME 8'h07
`define PSDM_OFF_GEAR 8'h08
`define PSDM_OFF_INVERT 8'h09
`define PSDM_OFF_SPEED_SRC 8'h0A
`define PSDM_OFF_MEAS_SPEED 8'h0B
`define PSDM_OFF_STATUS 8'h0C

`define PSDM_STAT_TRIP 0
`define PSDM_STAT_FAULT 1
`define PSDM_STAT_OVER_TOL 2
`define PSDM_STAT_TIMED_OUT 3

`define PSDM_CFG_DISABLED 2'h0
`define PSDM_CFG_TORQUE_LOAD 2'h1
`define PSDM_CFG_SPEED_LOAD 2'h2
`define PSDM_CFG_LOAD_ONLY 2'h3

`define PSDM_PROBE_DI 3
`define PSDM_PROBE_TERMINAL 16'h0017
`define PSDM_SPEED_SRC_PROBE 16'h024A

`define PSDM_DELAY_DEFAULT_S 10
`define PSDM_MAX_TIME_DEFAULT_S 10
`define PSDM_MS_PER_S 1000
`define PSDM_RST_CONFIG 2'h1
`define PSDM_RST_RESPONSE 8'h00
`define PSDM_RST_DEVIATION 16'h0096
`define PSDM_RST_INPUT_SEL 16'h0000
`define PSDM_RST_EDGE_SEL 1'h0
`define PSDM_RST_PULSES_REV 16'h0001
`define PSDM_RST_GEAR 16'h0001
`define PSDM_RST_INVERT 4'h0
`define PSDM_RST_SPEED_SRC 16'h0000

`define PSDM_CLK_HZ 20000000
`define PSDM_MAX_PULSE_HZ 32000
`define PSDM_TICK_CYCLES (`PSDM_CLK_HZ / `PSDM_MS_PER_S)
`define PSDM_SEC_PER_MIN 60
`define PSDM_RPM_NUM (`PSDM_SEC_PER_MIN * `PSDM_CLK_HZ)

`endif

// [shared/psdm_pkg.sv]
// Purpose: Types of the pulse probe speed deviation monitor.
// Assumes: Constants come from psdm_params.svh.
// Notes: State codes are Gray from idle to scale; scale back to idle flips both bits.
package psdm_pkg;

  typedef enum logic [1:0] {
    PSDM_CALC_IDLE = 2'b00,
    PSDM_CALC_DIV = 2'b01,
    PSDM_CALC_SCALE = 2'b11
  } psdm_calc_type;

  typedef enum logic [0:0] {
    PSDM_DIV_IDLE = 1'b0,
    PSDM_DIV_RUN = 1'b1
  } psdm_div_type;

endpackage

// [tb/psdm_monitor_chk.sv]
// Purpose: Port-level assertions for psdm_monitor.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Flags and response are registered, so relations allow one cycle of lag.
`timescale 1ns/1ps
module psdm_monitor_chk #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic clock_in, // System clock.
  input wire logic srst_in, // Synchronous reset.
  input wire logic [7:0] addr_in, // Register index.
  input wire logic wr_in, // Write strobe.
  input wire logic rd_in, // Read strobe.
  input wire logic [15:0] motor_speed_in, // Motor speed.
  input wire logic motor_on_in, // Motor switched on.
  input wire logic [31:0] rdata_out, // Read data.
  input wire logic [15:0] probe_measured_speed_out, // Probe speed.
  input wire logic deviation_trip_out, // Deviation trip.
  input wire logic load_failure_fault_out, // Load failure fault.
  input wire logic [7:0] response_out // Active response.
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  sequence s_trip_held;
    deviation_trip_out ##1 deviation_trip_out;
  endsequence
  sequence s_fault_held;
    load_failure_fault_out ##1 load_failure_fault_out;
  endsequence
  // Read data must not linger past its single valid cycle.
  chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read slot");
  chk_rdata_speed: assert property ($past(rd_in) && $past(addr_in) == 8'h0B |->
    rdata_out == {16'h0, $past(probe_measured_speed_out)}) else $error("speed readback wrong");
  chk_resp_zero: assert property (!deviation_trip_out && !load_failure_fault_out &&
    !$past(deviation_trip_out) && !$past(load_failure_fault_out) |-> response_out == 8'h0)
    else $error("response without trip");
  chk_resp_value: assert property (s_trip_held or s_fault_held |-> response_out != 8'h0)
    else $error("latched event with zero response");
  chk_trip_sticky: assert property (deviation_trip_out && !(wr_in && addr_in == 8'h0C) |=>
    deviation_trip_out) else $error("trip dropped without clear");
  chk_fault_sticky: assert property (load_failure_fault_out && !(wr_in && addr_in == 8'h0C) |=>
    load_failure_fault_out) else $error("fault dropped without clear");
  chk_trip_cause: assert property ($rose(deviation_trip_out) |->
    $past(probe_measured_speed_out) != 16'h0 || $past(motor_speed_in) != 16'h0)
    else $error("trip without speed difference");
  chk_fault_cause: assert property ($rose(load_failure_fault_out) |->
    $past(motor_on_in) && $past(motor_on_in, 2)) else $error("fault with motor off");
endmodule
bind psdm_monitor psdm_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock_in(clock_in),
  .srst_in(srst_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .motor_speed_in(motor_speed_in),
  .motor_on_in(motor_on_in), .rdata_out(rdata_out), .probe_measured_speed_out(probe_measured_speed_out),
  .deviation_trip_out(deviation_trip_out), .load_failure_fault_out(load_failure_fault_out),
  .response_out(response_out));

// [tb/psdm_monitor_tb_top.sv]
// Purpose: Self-checking bench for psdm_monitor.
// Assumes: One ms is 20 clocks; sensor period 1000 clocks.
// Notes: Unused digital inputs toggle so that a wrong source is visible.
`timescale 1ns/1ps
`include "psdm_params.svh"
module psdm_monitor_tb_top;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] motor_speed_in = 16'h0;
  logic motor_on_in = 1'b0;
  logic run = 1'b0;
  logic pulse;
  logic [9:0] cyc = 10'h0;
  logic [31:0] rdata_out;
  logic [15:0] speed;
  logic trip, fault;
  logic [7:0] resp;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] rst_tab [11] = '{32'h1, 32'h2710, 32'h0, 32'h96, 32'h0, 32'h0, 32'h1, 32'h2710, 32'h1,
    32'h0, 32'h0};
  always #25 clock_in = ~clock_in;
  always @(posedge clock_in) cyc <= cyc + 10'h1;
  psdm_pulse_sensor u_sensor (.clock_in(clock_in), .run_in(run), .period_in(32'h3E8), .pulse_out(pulse));
  psdm_monitor #(.TICK_CYCLES(20)) u_dut (.clock_in(clock_in), .srst_in(srst_in),
    .digital_in_in({pulse, cyc[9:7]}), .motor_speed_in(motor_speed_in), .motor_on_in(motor_on_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .probe_measured_speed_out(speed), .deviation_trip_out(trip), .load_failure_fault_out(fault),
    .response_out(resp));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 chk_word(rdata_out, exp);
  endtask
  // Polls with a bound; a hang ends the run instead of stalling it.
  task automatic wait_val(input int which, input logic [15:0] exp, input int lim);
    int n;
    n = 0;
    total_checks++;
    while ((which == 0 ? speed : which == 1 ? {15'h0, trip} : {15'h0, fault}) !== exp && n < lim) begin
      @(posedge clock_in);
      #1 n++;
    end
    if (n >= lim) begin
      fail($sformatf("wait %0d for %h timed out", which, exp));
      finish_test();
    end
  endtask
  function automatic logic [15:0] exp_speed(input longint ppr, input longint gear);
    longint v;
    v = (longint'(`PSDM_RPM_NUM) / (ppr * 64'h3E8)) * gear;
    return (v > 64'hFFFF) ? 16'hFFFF : 16'(v);
  endfunction
  initial begin
    repeat (5) @(posedge clock_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 11; i++) rd_chk(8'(i), rst_tab[i]);
    rd_chk(`PSDM_OFF_STATUS, 32'h0);
    reg_wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h0);
    reg_wr(`PSDM_OFF_MEAS_SPEED, 32'h1234);
    rd_chk(`PSDM_OFF_MEAS_SPEED, 32'h0);
    $display("test registers done");
    reg_wr(`PSDM_OFF_PULSES_REV, 32'h64);
    reg_wr(`PSDM_OFF_GEAR, 32'h2);
    reg_wr(`PSDM_OFF_MAX_TIME, 32'h64);
    reg_wr(`PSDM_OFF_INPUT_SEL, 32'h17);
    @(posedge clock_in) run <= 1'b1;
    wait_val(0, exp_speed(100, 2), 4000);
    rd_chk(`PSDM_OFF_MEAS_SPEED, {16'h0, exp_speed(100, 2)});
    reg_wr(`PSDM_OFF_GEAR, 32'h1);
    wait_val(0, exp_speed(100, 1), 4000);
    reg_wr(`PSDM_OFF_PULSES_REV, 32'h4);
    wait_val(0, exp_speed(4, 1), 4000);
    reg_wr(`PSDM_OFF_PULSES_REV, 32'h64);
    reg_wr(`PSDM_OFF_EDGE_SEL, 32'h1);
    wait_val(0, exp_speed(100, 1), 4000);
    $display("test speed done");
    @(posedge clock_in) motor_speed_in <= 16'h2F76;
    reg_wr(`PSDM_OFF_SPEED_SRC, 32'h24A);
    reg_wr(`PSDM_OFF_DELAY, 32'h3);
    reg_wr(`PSDM_OFF_CONFIG, 32'h2);
    reg_wr(`PSDM_OFF_RESPONSE, 32'h5);
    idle(200);
    chk_bit(trip, 1'b0);
    @(posedge clock_in) motor_speed_in <= 16'h2F77;
    idle(20);
    chk_bit(trip, 1'b0);
    wait_val(1, 16'h1, 200);
    chk_word({24'h0, resp}, 32'h5);
    rd_chk(`PSDM_OFF_STATUS, 32'h5);
    @(posedge clock_in) motor_speed_in <= 16'h2EE0;
    reg_wr(`PSDM_OFF_STATUS, 32'h1);
    idle(2);
    rd_chk(`PSDM_OFF_STATUS, 32'h0);
    chk_word({24'h0, resp}, 32'h0);
    reg_wr(`PSDM_OFF_CONFIG, 32'h3);
    $display("test deviation done");
    @(posedge clock_in) run <= 1'b0;
    idle(900);
    chk_bit(speed != 16'h0, 1'b1);
    wait_val(0, 16'h0, 2500);
    rd_chk(`PSDM_OFF_STATUS, 32'hC);
    $display("test timeout done");
    reg_wr(`PSDM_OFF_INVERT, 32'h8);
    @(posedge clock_in) motor_on_in <= 1'b1;
    idle(200);
    chk_bit(fault, 1'b0);
    reg_wr(`PSDM_OFF_INVERT, 32'h0);
    wait_val(2, 16'h1, 200);
    chk_word({24'h0, resp}, 32'h5);
    @(posedge clock_in) motor_on_in <= 1'b0;
    reg_wr(`PSDM_OFF_STATUS, 32'h2);
    idle(2);
    rd_chk(`PSDM_OFF_STATUS, 32'h4);
    reg_wr(`PSDM_OFF_RESPONSE, 32'h0);
    @(posedge clock_in) motor_on_in <= 1'b1;
    idle(200);
    chk_bit(fault, 1'b0);
    reg_wr(`PSDM_OFF_CONFIG, 32'h0);
    reg_wr(`PSDM_OFF_RESPONSE, 32'h5);
    idle(200);
    chk_bit(fault, 1'b0);
    $display("test load failure done");
    finish_test();
  end
endmodule

// [tb/psdm_pulse_sensor.sv]
// Purpose: Behavioural proximity sensor feeding the probe input.
// Assumes: Square wave, half the period high.
// Notes: Output idles low when stopped, like a switch with a pull-down.
`timescale 1ns/1ps
module psdm_pulse_sensor (
  input wire logic clock_in, // Clock.
  input wire logic run_in, // Emit pulses while high.
  input wire logic [31:0] period_in, // Clocks per pulse.
  output logic pulse_out = 1'b0 // Sensor output.
);
  logic [31:0] cnt_ff = 32'h0;
  logic [31:0] per;
  assign per = (period_in < 32'h271) ? 32'h271 : period_in;
  always @(posedge clock_in) begin
    if (!run_in) begin
      cnt_ff <= 32'h0;
      pulse_out <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff + 32'h1 >= per) ? 32'h0 : cnt_ff + 32'h1;
      pulse_out <= (cnt_ff < (per >> 1));
    end
  end
endmodule
